/* File: port_test_debug_pkg.sv */
package port_test_debug_pkg;

    // Seven test controls of one port, bit 6 first
    typedef struct packed {
        logic conformance_pattern;
        logic emphasis_override;
        logic speed_override;
        logic loop_state;
        logic conformance_receive;
        logic scrambler_off;
        logic loop_command;
    } port_test_cmd_t;

    typedef struct packed {
        logic indicator_field_a1;
        logic [7:0] indicator_field_a0;
    } indicator_a_t;

    typedef struct packed {
        logic capture_start;
        logic [2:0] port_sel;
        logic [4:0] mode_sel;
    } debug_ctrl_t;

    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_PHY_TEST_CMD,
        SEL_HOLD_QUIET,
        SEL_INDICATOR_A,
        SEL_INDICATOR_B,
        SEL_LINK_SNAPSHOT,
        SEL_LINK_CONFIG,
        SEL_TL_CONFIG,
        SEL_DEBUG_CTRL,
        SEL_DEBUG_DATA
    } reg_sel_t;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

endpackage

/* File: port_test_debug_regs.sv */
`timescale 1ns/1ps
`include "port_test_debug_regs_params.svh"

module port_test_debug_regs
    import port_test_debug_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter bit IS_UPSTREAM = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic autoload_valid,
    input wire logic [7:0] autoload_snapshot,
    input wire logic [15:0] autoload_link_config,
    input wire logic [31:0] debug_probe_in,
    output port_test_cmd_t [NUM_PORTS-1:0] port_test_cmd,
    output logic [NUM_PORTS-1:0] port_disable,
    output logic [NUM_PORTS-1:0] port_hold_quiet,
    output logic [NUM_PORTS-1:0] ltssm_stay_quiet,
    output logic [NUM_PORTS-1:0] port_pattern_rate,
    output indicator_a_t indicator_a,
    output logic [31:0] indicator_b,
    output logic [7:0] link_state_snapshot,
    output logic [15:0] link_layer_config,
    output logic adaptive_ack_policy,
    output logic fixed_detect_disable,
    output logic [7:0] transaction_layer_config,
    output logic [4:0] debug_mode_sel,
    output logic [2:0] debug_port_sel,
    output logic debug_capture_on
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Shared by read and write paths so both agree on the map
    function automatic reg_sel_t reg_decode(input logic [11:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        case ({addr[11:2], 2'h0})
            `OFS_PHY_TEST_CMD: sel = SEL_PHY_TEST_CMD;
            `OFS_HOLD_QUIET: sel = SEL_HOLD_QUIET;
            `OFS_INDICATOR_A: sel = SEL_INDICATOR_A;
            `OFS_INDICATOR_B: sel = SEL_INDICATOR_B;
            `OFS_LINK_SNAPSHOT: sel = SEL_LINK_SNAPSHOT;
            `OFS_LINK_CONFIG: sel = SEL_LINK_CONFIG;
            `OFS_TL_CONFIG: sel = SEL_TL_CONFIG;
            `OFS_DEBUG_CTRL: begin
                // Downstream instances answer as unmapped
                sel = IS_UPSTREAM ? SEL_DEBUG_CTRL : SEL_NONE;
            end
            `OFS_DEBUG_DATA: begin
                sel = IS_UPSTREAM ? SEL_DEBUG_DATA : SEL_NONE;
            end
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge_strobe(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register state

    port_test_cmd_t [NUM_PORTS-1:0] phy_cmd_q, phy_cmd_d;
    logic [NUM_PORTS-1:0] disable_q, disable_d;
    logic [NUM_PORTS-1:0] quiet_q, quiet_d;
    logic [NUM_PORTS-1:0] stay_quiet_q, stay_quiet_d;
    logic [NUM_PORTS-1:0] pattern_q, pattern_d;
    indicator_a_t ind_a_q, ind_a_d;
    logic [31:0] ind_b_q, ind_b_d;
    logic [7:0] snapshot_q, snapshot_d;
    logic [15:0] link_cfg_q, link_cfg_d;
    logic adaptive_q, adaptive_d;
    logic fix_detect_q, fix_detect_d;
    logic [7:0] tl_cfg_q, tl_cfg_d;
    debug_ctrl_t dbg_ctrl_q, dbg_ctrl_d;
    logic [31:0] dbg_data_q, dbg_data_d;

    ////////////////////////////////////////////////////////////////////////
    // Write channel state

    wr_state_t wr_state_q, wr_state_d;
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [11:0] wr_addr_q, wr_addr_d;
    logic [31:0] wr_data_q, wr_data_d;
    logic [3:0] wr_strb_q, wr_strb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic do_write;
    reg_sel_t wr_sel;

    // Address and data may arrive in either order or together
    always_comb begin
        wr_state_d = wr_state_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        wr_strb_d = wr_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        do_write = 1'b0;
        wr_sel = SEL_NONE;
        case (wr_state_q)
            WR_COLLECT: begin
                if (awvalid && awready_q) begin
                    aw_have_d = 1'b1;
                    wr_addr_d = awaddr;
                end
                if (wvalid && wready_q) begin
                    w_have_d = 1'b1;
                    wr_data_d = wdata;
                    wr_strb_d = wstrb;
                end
                if (aw_have_d && w_have_d) begin
                    wr_sel = reg_decode(wr_addr_d);
                    do_write = (wr_sel != SEL_NONE);
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = do_write ? `RESP_OKAY : `RESP_DECERR;
                    wr_state_d = WR_RESP;
                end
            end
            WR_RESP: begin
                if (bready) begin
                    bvalid_d = 1'b0;
                    wr_state_d = WR_COLLECT;
                end
            end
            default: begin
                wr_state_d = WR_COLLECT;
                bvalid_d = 1'b0;
            end
        endcase
        // One write at a time: no new beats while a response waits
        awready_d = (wr_state_d == WR_COLLECT) && !aw_have_d;
        wready_d = (wr_state_d == WR_COLLECT) && !w_have_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= WR_COLLECT;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_addr_q <= 12'h000;
            wr_data_q <= 32'h0000_0000;
            wr_strb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else begin
            wr_state_q <= wr_state_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            wr_strb_q <= wr_strb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register update

    // Writes touch only defined fields, so reserved bits stay zero
    always_comb begin
        logic [31:0] old_word;
        logic [31:0] new_word;
        old_word = 32'h0000_0000;
        new_word = 32'h0000_0000;
        phy_cmd_d = phy_cmd_q;
        disable_d = disable_q;
        quiet_d = quiet_q;
        pattern_d = pattern_q;
        ind_a_d = ind_a_q;
        ind_b_d = ind_b_q;
        snapshot_d = snapshot_q;
        link_cfg_d = link_cfg_q;
        tl_cfg_d = tl_cfg_q;
        dbg_ctrl_d = dbg_ctrl_q;
        dbg_data_d = dbg_data_q;
        if (do_write) begin
            old_word = read_word(wr_sel);
            new_word = merge_strobe(old_word, wr_data_d, wr_strb_d);
            case (wr_sel)
                SEL_PHY_TEST_CMD: begin
                    for (int p = 0; p < NUM_PORTS; p++) begin
                        phy_cmd_d[p] = new_word[p*`PHY_PORT_STRIDE +: 7];
                    end
                end
                SEL_HOLD_QUIET: begin
                    disable_d = new_word[`DISABLE_LSB +: NUM_PORTS];
                    quiet_d = new_word[`QUIET_LSB +: NUM_PORTS];
                    pattern_d = new_word[`PATTERN_RATE_LSB +: NUM_PORTS];
                end
                SEL_INDICATOR_A: begin
                    ind_a_d = new_word[8:0];
                end
                SEL_INDICATOR_B: begin
                    ind_b_d = new_word;
                end
                SEL_TL_CONFIG: begin
                    tl_cfg_d = new_word[7:0];
                end
                SEL_DEBUG_CTRL: begin
                    dbg_ctrl_d = new_word[8:0];
                end
                default: dbg_ctrl_d = dbg_ctrl_q; // Read-only, data ignored
            endcase
        end
        // Autoload replaces the read-only defaults
        if (autoload_valid) begin
            snapshot_d = autoload_snapshot;
            link_cfg_d = autoload_link_config;
        end
        // Capture runs every cycle while start is set
        if (dbg_ctrl_q.capture_start) begin
            dbg_data_d = debug_probe_in;
        end
        // Either control parks training in Detect.Quiet
        stay_quiet_d = disable_d | quiet_d;
        adaptive_d = link_cfg_d[`ADAPTIVE_ACK_BIT];
        fix_detect_d = link_cfg_d[`FIX_DETECT_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_cmd_q <= {NUM_PORTS{`RST_PHY_CMD}};
            disable_q <= NUM_PORTS'(`RST_PORT_BITS);
            quiet_q <= NUM_PORTS'(`RST_PORT_BITS);
            stay_quiet_q <= NUM_PORTS'(`RST_PORT_BITS);
            pattern_q <= NUM_PORTS'(`RST_PORT_BITS);
            ind_a_q <= `RST_INDICATOR_A;
            ind_b_q <= `RST_INDICATOR_B;
            snapshot_q <= `RST_LINK_SNAPSHOT;
            link_cfg_q <= `RST_LINK_CONFIG;
            adaptive_q <= 1'(`RST_LINK_CONFIG >> `ADAPTIVE_ACK_BIT);
            fix_detect_q <= 1'(`RST_LINK_CONFIG >> `FIX_DETECT_BIT);
            tl_cfg_q <= `RST_TL_CONFIG;
            dbg_ctrl_q <= `RST_DEBUG_CTRL;
            dbg_data_q <= `RST_DEBUG_DATA;
        end else begin
            phy_cmd_q <= phy_cmd_d;
            disable_q <= disable_d;
            quiet_q <= quiet_d;
            stay_quiet_q <= stay_quiet_d;
            pattern_q <= pattern_d;
            ind_a_q <= ind_a_d;
            ind_b_q <= ind_b_d;
            snapshot_q <= snapshot_d;
            link_cfg_q <= link_cfg_d;
            adaptive_q <= adaptive_d;
            fix_detect_q <= fix_detect_d;
            tl_cfg_q <= tl_cfg_d;
            dbg_ctrl_q <= dbg_ctrl_d;
            dbg_data_q <= dbg_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read view

    // Assembles one word; unused bits stay zero
    function automatic logic [31:0] read_word(input reg_sel_t sel);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (sel)
            SEL_PHY_TEST_CMD: begin
                for (int p = 0; p < NUM_PORTS; p++) begin
                    w[p*`PHY_PORT_STRIDE +: 7] = phy_cmd_q[p];
                end
            end
            SEL_HOLD_QUIET: begin
                w[`DISABLE_LSB +: NUM_PORTS] = disable_q;
                w[`QUIET_LSB +: NUM_PORTS] = quiet_q;
                w[`PATTERN_RATE_LSB +: NUM_PORTS] = pattern_q;
            end
            SEL_INDICATOR_A: w[8:0] = ind_a_q;
            SEL_INDICATOR_B: w = ind_b_q;
            SEL_LINK_SNAPSHOT: w[7:0] = snapshot_q;
            SEL_LINK_CONFIG: w[15:0] = link_cfg_q;
            SEL_TL_CONFIG: w[7:0] = tl_cfg_q;
            SEL_DEBUG_CTRL: w[8:0] = dbg_ctrl_q;
            SEL_DEBUG_DATA: w = dbg_data_q;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    rd_state_t rd_state_q, rd_state_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    // Data is sampled at the address edge and appears in the same cycle as rvalid
    always_comb begin
        reg_sel_t rd_sel;
        rd_sel = SEL_NONE;
        rd_state_d = rd_state_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rd_state_q)
            RD_IDLE: begin
                if (arvalid && arready_q) begin
                    rd_sel = reg_decode(araddr);
                    rdata_d = read_word(rd_sel);
                    rresp_d = (rd_sel == SEL_NONE) ?
                        `RESP_DECERR : `RESP_OKAY;
                    rvalid_d = 1'b1;
                    rd_state_d = RD_DATA;
                end
            end
            RD_DATA: begin
                if (rready) begin
                    rvalid_d = 1'b0;
                    rd_state_d = RD_IDLE;
                end
            end
            default: begin
                rd_state_d = RD_IDLE;
                rvalid_d = 1'b0;
            end
        endcase
        arready_d = (rd_state_d == RD_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= RD_IDLE;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign port_test_cmd = phy_cmd_q;
    assign port_disable = disable_q;
    assign port_hold_quiet = quiet_q;
    assign ltssm_stay_quiet = stay_quiet_q;
    assign port_pattern_rate = pattern_q;
    assign indicator_a = ind_a_q;
    assign indicator_b = ind_b_q;
    assign link_state_snapshot = snapshot_q;
    assign link_layer_config = link_cfg_q;
    assign adaptive_ack_policy = adaptive_q;
    assign fixed_detect_disable = fix_detect_q;
    assign transaction_layer_config = tl_cfg_q;
    // Mode zero is the training group; probe mux lives outside
    assign debug_mode_sel = dbg_ctrl_q.mode_sel;
    assign debug_port_sel = dbg_ctrl_q.port_sel;
    assign debug_capture_on = dbg_ctrl_q.capture_start;

endmodule

/* File: port_test_debug_regs_asserts.sv */
`timescale 1ns/1ps
module port_test_debug_regs_asserts
    import port_test_debug_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic autoload_valid,
    input wire logic [7:0] autoload_snapshot,
    input wire logic [15:0] autoload_link_config,
    input wire port_test_cmd_t [NUM_PORTS-1:0] port_test_cmd,
    input wire logic [NUM_PORTS-1:0] port_disable,
    input wire logic [NUM_PORTS-1:0] port_hold_quiet,
    input wire logic [NUM_PORTS-1:0] ltssm_stay_quiet,
    input wire logic [NUM_PORTS-1:0] port_pattern_rate,
    input wire logic [7:0] link_state_snapshot,
    input wire logic [15:0] link_layer_config,
    input wire logic adaptive_ack_policy,
    input wire logic fixed_detect_disable,
    input wire logic [4:0] debug_mode_sel,
    input wire logic [2:0] debug_port_sel,
    input wire logic debug_capture_on
);
    // Single clock domain, one reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic aw_hs = awvalid && awready;
    wire logic w_hs = wvalid && wready;
    ////////////////////////////////////////////////////////////////////////
    // Reset values seen at the first edge out of reset
    chk_reset_ports: assert property ($rose(aresetn) |->
        port_disable == '0 && port_hold_quiet == '0)
        else $error("disable or hold not clear after reset");
    chk_reset_cmd: assert property ($rose(aresetn) |->
        port_test_cmd == '0)
        else $error("test commands not clear after reset");
    chk_reset_rate: assert property ($rose(aresetn) |->
        port_pattern_rate == '0)
        else $error("pattern rate not clear after reset");
    chk_reset_cfg: assert property ($rose(aresetn) |->
        link_layer_config == 16'h0004)
        else $error("link config reset value wrong");
    // Outputs tied to their sources
    chk_quiet_or: assert property (
        ltssm_stay_quiet == (port_disable | port_hold_quiet))
        else $error("stay quiet is not disable or hold");
    chk_snap_load: assert property (autoload_valid |=>
        link_state_snapshot == $past(autoload_snapshot))
        else $error("snapshot not loaded");
    chk_ro_hold: assert property (!autoload_valid |=>
        $stable(link_state_snapshot) && $stable(link_layer_config))
        else $error("read-only field changed without autoload");
    chk_cfg_load: assert property (autoload_valid |=>
        link_layer_config == $past(autoload_link_config))
        else $error("link config not loaded");
    chk_cfg_bits: assert property (
        {fixed_detect_disable, adaptive_ack_policy} == link_layer_config[5:4])
        else $error("policy outputs differ from config bits");
    // Debug selectors move only on a bus write; a reset edge is exempt
    chk_debug_write: assert property ($past(aresetn) &&
        !$stable({debug_mode_sel, debug_port_sel, debug_capture_on})
        |-> $past(aw_hs || w_hs))
        else $error("debug control changed without write");
    chk_write_resp: assert property (aw_hs && w_hs |=> bvalid)
        else $error("no write response one cycle after write");
    chk_read_resp: assert property (arvalid && arready |=> rvalid)
        else $error("no read data one cycle after address");
    cover property (autoload_valid);
    cover property (debug_capture_on && aw_hs);
    cover property (aw_hs && w_hs);
endmodule

/* File: port_test_debug_regs_params.svh */
`ifndef PORT_TEST_DEBUG_REGS_PARAMS_SVH
`define PORT_TEST_DEBUG_REGS_PARAMS_SVH

// Register byte offsets
`define OFS_PHY_TEST_CMD 12'h320
`define OFS_HOLD_QUIET 12'h324
`define OFS_INDICATOR_A 12'h328
`define OFS_INDICATOR_B 12'h32C
`define OFS_LINK_SNAPSHOT 12'h33C
`define OFS_LINK_CONFIG 12'h340
`define OFS_TL_CONFIG 12'h344
`define OFS_DEBUG_CTRL 12'h348
`define OFS_DEBUG_DATA 12'h34C

// Field positions
`define PHY_PORT_STRIDE 8
`define DISABLE_LSB 0
`define QUIET_LSB 8
`define PATTERN_RATE_LSB 16
`define INDICATOR_A1_BIT 8
`define ADAPTIVE_ACK_BIT 4
`define FIX_DETECT_BIT 5
`define DEBUG_MODE_LSB 0
`define DEBUG_PORT_LSB 5
`define DEBUG_START_BIT 8

// Reset values
`define RST_PORT_BITS 3'h0
`define RST_PHY_CMD 7'h00
`define RST_INDICATOR_A 9'h000
`define RST_INDICATOR_B 32'h0000_0000
`define RST_LINK_SNAPSHOT 8'h00
`define RST_LINK_CONFIG 16'h0004
`define RST_TL_CONFIG 8'h03
`define RST_DEBUG_CTRL 9'h000
`define RST_DEBUG_DATA 32'h0000_0000

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

/* File: port_test_debug_regs_tb.sv */
`timescale 1ns/1ps
`include "port_test_debug_regs_params.svh"
module port_test_debug_regs_tb
    import port_test_debug_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, autoload_valid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, debug_probe_in, indicator_b;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] autoload_snapshot, link_state_snapshot;
    logic [7:0] transaction_layer_config;
    logic [15:0] autoload_link_config, link_layer_config;
    port_test_cmd_t [2:0] port_test_cmd;
    logic [2:0] port_disable, port_hold_quiet, ltssm_stay_quiet;
    logic [2:0] port_pattern_rate, debug_port_sel;
    logic [4:0] debug_mode_sel;
    indicator_a_t indicator_a;
    logic adaptive_ack_policy, fixed_detect_disable, debug_capture_on;
    int bad_count = 0, cmp_count = 0;

    port_test_debug_regs #(.NUM_PORTS(3), .IS_UPSTREAM(1'b1)) i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .autoload_valid,
        .autoload_snapshot, .autoload_link_config, .debug_probe_in,
        .port_test_cmd, .port_disable, .port_hold_quiet, .ltssm_stay_quiet,
        .port_pattern_rate, .indicator_a, .indicator_b, .link_state_snapshot,
        .link_layer_config, .adaptive_ack_policy, .fixed_detect_disable,
        .transaction_layer_config, .debug_mode_sel, .debug_port_sel,
        .debug_capture_on
    );

    // 250 MHz clock
    always #2 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict;
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Each channel released on its own handshake edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic aw = 1'b1;
        logic w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (awready === 1'b1) aw = 1'b0;
            if (wready === 1'b1) w = 1'b0;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp("rdata", e, rdata);
        cmp("rresp", 32'(er), 32'(rresp));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`OFS_PHY_TEST_CMD, 32'h0, `RESP_OKAY);
        rd(`OFS_HOLD_QUIET, 32'h0, `RESP_OKAY);
        rd(`OFS_INDICATOR_A, 32'h0, `RESP_OKAY);
        rd(`OFS_INDICATOR_B, 32'h0, `RESP_OKAY);
        rd(`OFS_LINK_SNAPSHOT, 32'h0, `RESP_OKAY);
        rd(`OFS_LINK_CONFIG, 32'h4, `RESP_OKAY);
        rd(`OFS_TL_CONFIG, 32'h3, `RESP_OKAY);
        rd(`OFS_DEBUG_CTRL, 32'h0, `RESP_OKAY);
        rd(`OFS_DEBUG_DATA, 32'h0, `RESP_OKAY);
    endtask

    // Byte lane 1 cleared alone hits only port 1
    task automatic t_phy;
        wr(`OFS_PHY_TEST_CMD, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
        rd(`OFS_PHY_TEST_CMD, 32'h007F_7F7F, `RESP_OKAY);
        cmp("port_test_cmd", 32'h001F_FFFF, 32'(port_test_cmd));
        wr(`OFS_PHY_TEST_CMD, 32'h0, 4'h2, `RESP_OKAY);
        rd(`OFS_PHY_TEST_CMD, 32'h007F_007F, `RESP_OKAY);
        cmp("port_test_cmd", 32'h001F_C07F, 32'(port_test_cmd));
    endtask

    task automatic t_quiet;
        wr(`OFS_HOLD_QUIET, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
        rd(`OFS_HOLD_QUIET, 32'h0007_0707, `RESP_OKAY);
        wr(`OFS_HOLD_QUIET, 32'h0005_0102, 4'hF, `RESP_OKAY);
        cmp("port_disable", 32'h2, 32'(port_disable));
        cmp("port_hold_quiet", 32'h1, 32'(port_hold_quiet));
        cmp("ltssm_stay_quiet", 32'h3, 32'(ltssm_stay_quiet));
        cmp("port_pattern_rate", 32'h5, 32'(port_pattern_rate));
    endtask

    task automatic t_store;
        wr(`OFS_INDICATOR_A, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
        rd(`OFS_INDICATOR_A, 32'h0000_01FF, `RESP_OKAY);
        cmp("indicator_a", 32'h1FF, 32'(indicator_a));
        wr(`OFS_INDICATOR_B, 32'hA5C3_3C5A, 4'hF, `RESP_OKAY);
        cmp("indicator_b", 32'hA5C3_3C5A, indicator_b);
        wr(`OFS_TL_CONFIG, 32'hFFFF_FF96, 4'hF, `RESP_OKAY);
        rd(`OFS_TL_CONFIG, 32'h96, `RESP_OKAY);
        cmp("tl_config", 32'h96, 32'(transaction_layer_config));
    endtask

    // Software writes get OKAY but change nothing; only autoload changes them
    task automatic t_ro;
        wr(`OFS_LINK_SNAPSHOT, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
        wr(`OFS_LINK_CONFIG, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
        rd(`OFS_LINK_SNAPSHOT, 32'h0, `RESP_OKAY);
        rd(`OFS_LINK_CONFIG, 32'h4, `RESP_OKAY);
        autoload_snapshot <= 8'hA5;
        autoload_link_config <= 16'h0020;
        autoload_valid <= 1'b1;
        @(posedge aclk);
        autoload_valid <= 1'b0;
        rd(`OFS_LINK_SNAPSHOT, 32'hA5, `RESP_OKAY);
        rd(`OFS_LINK_CONFIG, 32'h20, `RESP_OKAY);
        cmp("adaptive_ack", 32'h0, 32'(adaptive_ack_policy));
        cmp("fixed_detect", 32'h1, 32'(fixed_detect_disable));
    endtask

    // Capture runs while start is set, freezes when cleared
    task automatic t_debug;
        wr(`OFS_DEBUG_CTRL, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
        rd(`OFS_DEBUG_CTRL, 32'h1FF, `RESP_OKAY);
        debug_probe_in <= 32'hC33C_A55A;
        wr(`OFS_DEBUG_DATA, 32'h0, 4'hF, `RESP_OKAY);
        rd(`OFS_DEBUG_DATA, 32'hC33C_A55A, `RESP_OKAY);
        wr(`OFS_DEBUG_CTRL, 32'h40, 4'hF, `RESP_OKAY);
        cmp("debug_sel", 32'h40, 32'({debug_capture_on, debug_port_sel,
            debug_mode_sel}));
        debug_probe_in <= 32'h1234_5678;
        rd(`OFS_DEBUG_DATA, 32'hC33C_A55A, `RESP_OKAY);
    endtask

    task automatic t_unmapped;
        wr(12'h350, 32'hFFFF_FFFF, 4'hF, `RESP_DECERR);
        rd(12'h350, 32'h0, `RESP_DECERR);
        rd(12'h330, 32'h0, `RESP_DECERR);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence, with a second reset in mid-run
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, autoload_valid} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {autoload_snapshot, autoload_link_config, debug_probe_in} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_phy();
        t_quiet();
        t_store();
        t_ro();
        t_debug();
        t_unmapped();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        give_verdict();
    end

    // Hang guard, far beyond the roughly 150 cycles needed
    initial begin
        #20000;
        bad_count++;
        give_verdict();
    end
endmodule

bind port_test_debug_regs port_test_debug_regs_asserts #(
    .NUM_PORTS(NUM_PORTS)
) i_chk (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .arvalid, .arready, .rvalid, .autoload_valid, .autoload_snapshot,
    .autoload_link_config, .port_test_cmd, .port_disable, .port_hold_quiet,
    .ltssm_stay_quiet, .port_pattern_rate, .link_state_snapshot,
    .link_layer_config, .adaptive_ack_policy, .fixed_detect_disable,
    .debug_mode_sel, .debug_port_sel, .debug_capture_on
);
